// *** verilog/nic_pkg.sv ***
// Constants and helpers shared by the nested interrupt controller
package nic_pkg;
    ////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the 8-bit register port
    localparam logic [7:0] NIC_ADDR_PRIO0 = 8'h24;
    localparam logic [7:0] NIC_ADDR_PRIO3 = 8'h27;
    localparam logic [7:0] NIC_ADDR_EXT_CTRL = 8'h28;
    localparam logic [7:0] NIC_PRIO_RESET = 8'hff;
    localparam logic [7:0] NIC_EXT_RESET = 8'h00;
    localparam logic [3:0] NIC_PRIO3_RO_ONES = 4'hf;
    // External control field positions
    localparam int NIC_EXT_UPPER_SENS = 6;
    localparam int NIC_EXT_POL_B = 5;
    localparam int NIC_EXT_LOWER_SENS = 3;
    localparam int NIC_EXT_POL_A = 2;
    localparam int NIC_EXT_TLI_SENS = 1;
    localparam int NIC_EXT_TLI_EN = 0;
    // Sensitivity codes
    localparam logic [1:0] NIC_SENS_FALL_LOW = 2'h0;
    localparam logic [1:0] NIC_SENS_RISE = 2'h1;
    localparam logic [1:0] NIC_SENS_FALL = 2'h2;
    localparam logic [1:0] NIC_SENS_BOTH = 2'h3;
    ////////////////////////////////////////////////////////////////////
    // Level encodings of the two condition code bits
    localparam logic [1:0] NIC_LVL0 = 2'h2;
    localparam logic [1:0] NIC_LVL1 = 2'h1;
    localparam logic [1:0] NIC_LVL2 = 2'h0;
    localparam logic [1:0] NIC_LVL3 = 2'h3;
    localparam int NIC_CC_BIT_HIGH = 5;
    localparam int NIC_CC_BIT_LOW = 3;
    ////////////////////////////////////////////////////////////////////
    // Vector numbers and addresses
    localparam int NIC_NUM_VEC = 14;
    localparam logic [3:0] NIC_VEC_TLI = 4'h0;
    localparam logic [3:0] NIC_VEC_CLK = 4'h1;
    localparam logic [3:0] NIC_VEC_EXT0 = 4'h2;
    localparam logic [3:0] NIC_VEC_EXT3 = 4'h5;
    localparam logic [3:0] NIC_VEC_UNUSED = 4'h6;
    localparam logic [3:0] NIC_VEC_SPI = 4'h7;
    localparam logic [3:0] NIC_VEC_ART = 4'hd;
    localparam logic [3:0] NIC_VEC_TRAP = 4'he;
    localparam logic [3:0] NIC_VEC_RESET = 4'hf;
    localparam logic [15:0] NIC_VADDR_RESET = 16'hfffe;
    localparam logic [15:0] NIC_VADDR_TRAP = 16'hfffc;
    localparam logic [15:0] NIC_VADDR_VEC0 = 16'hfffa;

    // Pair code to ordinal level, 0 lowest and 3 masked
    function automatic logic [1:0] nic_rank(input logic [1:0] pair);
        unique case (pair)
            NIC_LVL0: nic_rank = 2'h0;
            NIC_LVL1: nic_rank = 2'h1;
            NIC_LVL2: nic_rank = 2'h2;
            default: nic_rank = 2'h3;
        endcase
    endfunction : nic_rank
endpackage : nic_pkg

// *** verilog/nic_ext_sense.sv ***
// Edge and level detector for one external interrupt vector
`timescale 1ns/1ns
module nic_ext_sense #(
    parameter int PINS = 4,
    parameter bit HAS_INV = 1'b0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Synchronised pins and their enables
    input wire logic [PINS-1:0] i_pins,
    input wire logic [PINS-1:0] i_pin_en,
    // Configuration and clear
    input wire logic [1:0] i_sens,
    input wire logic i_inv,
    input wire logic i_clr,
    // Request towards arbitration
    output logic o_pend
);
    typedef struct packed {
        logic [PINS-1:0] prev;
        logic latch;
    } nic_sense_t;
    nic_sense_t st_reg, st_next;
    logic [PINS-1:0] lvl;
    logic [PINS-1:0] plv;
    logic rise, fall, hit;

    // Inversion only on vectors that own a polarity bit
    always_comb begin
        lvl = (HAS_INV && i_inv) ? ~i_pins : i_pins;
        // Old sample seen through the current polarity, so a polarity write makes no false edge
        plv = (HAS_INV && i_inv) ? ~st_reg.prev : st_reg.prev;
        rise = |(lvl & ~plv & i_pin_en);
        fall = |(~lvl & plv & i_pin_en);
        unique case (i_sens)
            nic_pkg::NIC_SENS_RISE: hit = rise;
            nic_pkg::NIC_SENS_FALL: hit = fall;
            nic_pkg::NIC_SENS_BOTH: hit = rise | fall;
            default: hit = fall;
        endcase
        st_next.prev = i_pins;
        // A new edge wins over the clear from entry
        st_next.latch = hit | (st_reg.latch & ~i_clr);
        o_pend = st_reg.latch | ((i_sens == nic_pkg::NIC_SENS_FALL_LOW) & |(~lvl & i_pin_en));
    end

    // Pins idle high, so prev starts at ones
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '{prev: '1, latch: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : nic_ext_sense

// *** verilog/nic_arbiter.sv ***
// Combinational winner selection among pending vectors
`timescale 1ns/1ns
module nic_arbiter (
    // Requests and priorities
    input wire logic [13:0] i_pend,
    input wire logic [3:0][7:0] i_prio,
    input wire logic [1:0] i_cur_rank,
    // Halt restriction
    input wire logic i_halt_only,
    input wire logic [13:0] i_halt_mask,
    // Winner
    output logic o_valid,
    output logic [3:0] o_vec
);
    logic [2:0] best;
    logic [2:0] r;
    logic ok;

    // Walk from lowest hardware priority so ties go to the lower number
    always_comb begin
        best = 3'h0;
        r = 3'h0;
        ok = 1'b0;
        o_valid = 1'b0;
        o_vec = 4'h0;
        for (int i = nic_pkg::NIC_NUM_VEC - 1; i >= 0; i--) begin
            // Pair of vector i sits in register i/4 at bits 2*(i%4) upward
            r = {1'b0, nic_pkg::nic_rank(i_prio[i / 4][2 * (i % 4) +: 2])};
            if (i == 0) begin
                r = 3'h4;
            end
            ok = i_pend[i] && (i != 6) && (!i_halt_only || i_halt_mask[i]);
            ok = ok && ((i == 0) || (r > {1'b0, i_cur_rank}));
            if (ok && (!o_valid || r >= best)) begin
                o_valid = 1'b1;
                best = r;
                o_vec = 4'(i);
            end
        end
    end
endmodule : nic_arbiter

// *** verilog/nic_ctrl.sv ***
// Nested interrupt controller with level, priority and external sensing
`timescale 1ns/1ns
module nic_ctrl (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Core instruction effects
    input wire logic i_instr_boundary,
    input wire logic i_op_enable_irq,
    input wire logic i_op_disable_irq,
    input wire logic i_op_halt,
    input wire logic i_op_wait_irq,
    input wire logic i_op_trap,
    input wire logic i_op_irq_return,
    input wire logic i_op_pop_cc,
    input wire logic [1:0] i_pop_level,
    // Peripheral requests and modes
    input wire logic i_clock_timebase_req,
    input wire logic [6:0] i_periph_req,
    input wire logic i_spi_slave,
    input wire logic i_art_ext_clock,
    input wire logic i_flash_variant,
    input wire logic i_active_halt,
    // Pins and their enables
    input wire logic i_top_level_pin,
    input wire logic [3:0] i_port_a_pins,
    input wire logic [2:0] i_port_f_pins,
    input wire logic [7:0] i_port_b_pins,
    input wire logic [14:0] i_pin_en,
    // Core side results
    output logic o_take,
    output logic [3:0] o_vector,
    output logic [15:0] o_vector_addr,
    output logic o_level_bit_high,
    output logic o_level_bit_low,
    output logic o_jump_if_masked,
    output logic o_jump_if_unmasked,
    output logic o_halted,
    output logic o_halt_exit
);
    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [1:0] level;
        logic [3:0][7:0] prio;
        logic [7:0] ext_ctrl;
        logic tli_prev;
        logic tli_latch;
        logic halted;
        logic reset_pend;
        logic take;
        logic [3:0] vec;
        logic [15:0] vaddr;
        logic [7:0] rdata;
        logic masked;
        logic halt_exit;
    } nic_state_t;
    nic_state_t st_reg, st_next;

    logic [13:0] pend;
    logic [13:0] halt_mask;
    logic [3:0] ext_pend;
    logic [3:0] ext_clr;
    logic win_valid;
    logic [3:0] win_vec;
    logic ext_wr_ok;
    logic tli_edge;
    logic [1:0] wpair;

    ////////////////////////////////////////////////////////////////////
    // External vectors, polarity only on the first and third
    nic_ext_sense #(.PINS(4), .HAS_INV(1'b1)) u_ext_first (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_pins(st_reg.sync2[3:0]),
        .i_pin_en(i_pin_en[3:0]),
        .i_sens(st_reg.ext_ctrl[nic_pkg::NIC_EXT_LOWER_SENS +: 2]),
        .i_inv(st_reg.ext_ctrl[nic_pkg::NIC_EXT_POL_A]),
        .i_clr(ext_clr[0]),
        .o_pend(ext_pend[0])
    );
    nic_ext_sense #(.PINS(3), .HAS_INV(1'b0)) u_ext_second (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_pins(st_reg.sync2[6:4]),
        .i_pin_en(i_pin_en[6:4]),
        .i_sens(st_reg.ext_ctrl[nic_pkg::NIC_EXT_LOWER_SENS +: 2]),
        .i_inv(1'b0),
        .i_clr(ext_clr[1]),
        .o_pend(ext_pend[1])
    );
    nic_ext_sense #(.PINS(4), .HAS_INV(1'b1)) u_ext_third (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_pins(st_reg.sync2[10:7]),
        .i_pin_en(i_pin_en[10:7]),
        .i_sens(st_reg.ext_ctrl[nic_pkg::NIC_EXT_UPPER_SENS +: 2]),
        .i_inv(st_reg.ext_ctrl[nic_pkg::NIC_EXT_POL_B]),
        .i_clr(ext_clr[2]),
        .o_pend(ext_pend[2])
    );
    nic_ext_sense #(.PINS(4), .HAS_INV(1'b0)) u_ext_fourth (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_pins(st_reg.sync2[14:11]),
        .i_pin_en(i_pin_en[14:11]),
        .i_sens(st_reg.ext_ctrl[nic_pkg::NIC_EXT_UPPER_SENS +: 2]),
        .i_inv(1'b0),
        .i_clr(ext_clr[3]),
        .o_pend(ext_pend[3])
    );

    ////////////////////////////////////////////////////////////////////
    // Request vector and halt capability
    always_comb begin
        pend = {i_periph_req, 1'b0, ext_pend, i_clock_timebase_req,
                st_reg.tli_latch & st_reg.ext_ctrl[nic_pkg::NIC_EXT_TLI_EN]};
        halt_mask = {i_art_ext_clock, 5'h00, i_spi_slave, 1'b0, 6'h3f};
        if (i_flash_variant && i_active_halt) begin
            halt_mask = 14'h0002;
        end
    end

    nic_arbiter u_arb (
        .i_pend(pend),
        .i_prio(st_reg.prio),
        .i_cur_rank(nic_pkg::nic_rank(st_reg.level)),
        .i_halt_only(st_reg.halted),
        .i_halt_mask(halt_mask),
        .o_valid(win_valid),
        .o_vec(win_vec)
    );

    ////////////////////////////////////////////////////////////////////
    // Sensitivity writes and the pending clears they cause
    always_comb begin
        ext_wr_ok = i_wr && (i_addr == nic_pkg::NIC_ADDR_EXT_CTRL) && (st_reg.level == nic_pkg::NIC_LVL3);
        ext_clr = 4'h0;
        if (ext_wr_ok) begin
            // Any changed field drops stale requests of its vectors
            if (i_wdata[7:6] != st_reg.ext_ctrl[7:6]) ext_clr[3:2] = 2'h3;
            if (i_wdata[4:3] != st_reg.ext_ctrl[4:3]) ext_clr[1:0] = 2'h3;
            if (i_wdata[5] != st_reg.ext_ctrl[5]) ext_clr[2] = 1'b1;
            if (i_wdata[2] != st_reg.ext_ctrl[2]) ext_clr[0] = 1'b1;
        end
        // Edge latches drop when their routine is entered
        if (st_next.take && st_next.vec >= nic_pkg::NIC_VEC_EXT0 && st_next.vec <= nic_pkg::NIC_VEC_EXT3) begin
            ext_clr[2'(st_next.vec - nic_pkg::NIC_VEC_EXT0)] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        wpair = 2'h0;
        st_next.sync1 = {i_top_level_pin, i_port_b_pins, i_port_f_pins, i_port_a_pins};
        st_next.sync2 = st_reg.sync1;
        st_next.take = 1'b0;
        st_next.halt_exit = 1'b0;
        st_next.rdata = 8'h00;
        // Top-level pin edge as chosen by its sense bit
        st_next.tli_prev = st_reg.sync2[15];
        tli_edge = st_reg.ext_ctrl[nic_pkg::NIC_EXT_TLI_SENS] ? (st_reg.sync2[15] & ~st_reg.tli_prev)
                                                             : (~st_reg.sync2[15] & st_reg.tli_prev);
        // Register reads, unmapped addresses read zero
        if (i_rd) begin
            if (i_addr >= nic_pkg::NIC_ADDR_PRIO0 && i_addr <= nic_pkg::NIC_ADDR_PRIO3) begin
                st_next.rdata = st_reg.prio[2'(i_addr - nic_pkg::NIC_ADDR_PRIO0)];
            end else if (i_addr == nic_pkg::NIC_ADDR_EXT_CTRL) begin
                st_next.rdata = st_reg.ext_ctrl;
            end
        end
        // Priority writes, each pair judged on its own
        if (i_wr && i_addr >= nic_pkg::NIC_ADDR_PRIO0 && i_addr <= nic_pkg::NIC_ADDR_PRIO3) begin
            for (int p = 0; p < 4; p++) begin
                wpair = i_wdata[2 * p +: 2];
                if (wpair != nic_pkg::NIC_LVL0) begin
                    st_next.prio[2'(i_addr - nic_pkg::NIC_ADDR_PRIO0)][2 * p +: 2] = wpair;
                end
            end
        end
        st_next.prio[3][7:4] = nic_pkg::NIC_PRIO3_RO_ONES;
        // Enable bit always writable, sense only while disabled
        if (i_wr && i_addr == nic_pkg::NIC_ADDR_EXT_CTRL) begin
            st_next.ext_ctrl[nic_pkg::NIC_EXT_TLI_EN] = i_wdata[nic_pkg::NIC_EXT_TLI_EN];
            if (!st_reg.ext_ctrl[nic_pkg::NIC_EXT_TLI_EN]) begin
                st_next.ext_ctrl[nic_pkg::NIC_EXT_TLI_SENS] = i_wdata[nic_pkg::NIC_EXT_TLI_SENS];
            end
        end
        if (ext_wr_ok) begin
            st_next.ext_ctrl[7:2] = i_wdata[7:2];
        end
        // Level changing instructions, effective until the next one
        if (i_op_enable_irq || i_op_halt || i_op_wait_irq) begin
            st_next.level = nic_pkg::NIC_LVL0;
        end
        if (i_op_disable_irq) begin
            st_next.level = nic_pkg::NIC_LVL3;
        end
        if (i_op_irq_return || i_op_pop_cc) begin
            st_next.level = i_pop_level;
        end
        if (i_op_halt) begin
            st_next.halted = 1'b1;
        end
        // Entry: reset first, then trap, then the arbitration winner
        if (st_reg.reset_pend) begin
            st_next.reset_pend = 1'b0;
            st_next.take = 1'b1;
            st_next.vec = nic_pkg::NIC_VEC_RESET;
            st_next.vaddr = nic_pkg::NIC_VADDR_RESET;
            st_next.level = nic_pkg::NIC_LVL3;
        end else if (i_op_trap) begin
            st_next.take = 1'b1;
            st_next.vec = nic_pkg::NIC_VEC_TRAP;
            st_next.vaddr = nic_pkg::NIC_VADDR_TRAP;
            st_next.level = nic_pkg::NIC_LVL3;
        end else if (win_valid && (i_instr_boundary || st_reg.halted)) begin
            // A raised priority shows up here as a fresh winner
            st_next.take = 1'b1;
            st_next.vec = win_vec;
            st_next.vaddr = 16'(nic_pkg::NIC_VADDR_VEC0 - {11'h000, win_vec, 1'b0});
            st_next.level = (win_vec == nic_pkg::NIC_VEC_TLI) ? nic_pkg::NIC_LVL3
                          : st_reg.prio[win_vec[3:2]][2 * win_vec[1:0] +: 2];
            st_next.halt_exit = st_reg.halted;
            st_next.halted = 1'b0;
        end
        // A fresh edge beats the clear from entry
        st_next.tli_latch = tli_edge | (st_reg.tli_latch & ~(st_next.take && st_next.vec == nic_pkg::NIC_VEC_TLI));
        st_next.masked = (st_next.level == nic_pkg::NIC_LVL3);
    end

    // Reset leaves level 3 and a reset entry queued
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '{sync1: '1, sync2: '1, level: nic_pkg::NIC_LVL3,
                        prio: {4{nic_pkg::NIC_PRIO_RESET}}, ext_ctrl: nic_pkg::NIC_EXT_RESET,
                        tli_prev: 1'b1, tli_latch: 1'b0, halted: 1'b0, reset_pend: 1'b1,
                        take: 1'b0, vec: 4'h0, vaddr: 16'h0000, rdata: 8'h00,
                        masked: 1'b1, halt_exit: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign o_rdata = st_reg.rdata;
    assign o_take = st_reg.take;
    assign o_vector = st_reg.vec;
    assign o_vector_addr = st_reg.vaddr;
    assign o_level_bit_high = st_reg.level[1];
    assign o_level_bit_low = st_reg.level[0];
    assign o_jump_if_masked = st_reg.masked;
    assign o_jump_if_unmasked = ~st_reg.masked;
    assign o_halted = st_reg.halted;
    assign o_halt_exit = st_reg.halt_exit;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    AST_FORCED_LEVEL3: assert property (o_take && (o_vector == 4'h0 || o_vector >= 4'he) |-> o_level_bit_high && o_level_bit_low) else $error("forced level missing");
    AST_NO_LEVEL0_STORE: assert property (i_wr && i_addr == 8'h24 && i_wdata[1:0] == 2'h2 |=> st_reg.prio[0][1:0] == $past(st_reg.prio[0][1:0])) else $error("level 0 stored");
    AST_PRIO3_TOP: assert property (st_reg.prio[3][7:4] == 4'hf) else $error("read-only nibble changed");
    AST_ENABLE_LEVEL: assert property (i_op_enable_irq && !i_op_trap && !win_valid && !st_reg.reset_pend |=> o_level_bit_high && !o_level_bit_low) else $error("enable did not load 10");
    AST_JUMP_TRACK: assert property (o_jump_if_masked == (o_level_bit_high && o_level_bit_low) && (o_jump_if_unmasked != o_jump_if_masked)) else $error("jump condition wrong");
    AST_SENS_GATED: assert property (i_wr && i_addr == 8'h28 && st_reg.level != 2'h3 |=> $stable(st_reg.ext_ctrl[7:2])) else $error("sensitivity written off level 3");
    AST_RETURN_LEVEL: assert property (i_op_irq_return && !i_op_trap && !win_valid && !st_reg.reset_pend |=> st_reg.level == $past(i_pop_level)) else $error("return level wrong");
    AST_UNUSED_SLOT: assert property (!(o_take && o_vector == 4'h6)) else $error("unused vector taken");
    AST_BOUNDARY: assert property (o_take && o_vector < 4'he |-> $past(i_instr_boundary) || $past(st_reg.halted)) else $error("entry off boundary");
    AST_HALT_EXIT: assert property (o_halt_exit |-> o_take && (o_vector <= 4'h5 || o_vector == 4'h7 || o_vector == 4'hd)) else $error("illegal halt exit");
endmodule : nic_ctrl

// *** testbench/nic_src_model.sv ***
// Peripheral request source standing in for a status flag
`timescale 1ns/1ns
module nic_src_model #(
    parameter logic [3:0] VEC = 4'h1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Raise strobe and core entry
    input wire logic i_raise,
    input wire logic i_take,
    input wire logic [3:0] i_vector,
    // Request level
    output logic o_req
);
    ////////////////////////////////////////////////////////////////////
    // Flag held until its routine is entered, so a masked request waits
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_req <= 1'b0;
        end else if (i_raise) begin
            o_req <= 1'b1;
        end else if (i_take && i_vector == VEC) begin
            o_req <= 1'b0;
        end
    end
endmodule : nic_src_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the nested interrupt controller
`timescale 1ns/1ns
module tb_top;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [6:0] ops = 7'h00;
    logic [1:0] pop_lvl = 2'h2;
    logic [3:0] pa = 4'hf;
    logic [14:0] pin_en = 15'h0001;
    logic [1:0] raise = 2'h0;
    logic bnd = 1'b1;
    logic tlp = 1'b1;
    logic spi = 1'b0;
    logic [1:0] fa = 2'h0;
    logic [2:0] pf = 3'h7;
    logic [1:0] req;
    logic [7:0] rdata;
    logic take, hlt, hx, lh, ll, jm, jn;
    logic [3:0] vec;
    logic [15:0] vaddr;
    logic [22:0] cap = 23'h0;
    int n_take = 0;
    int n_exp = 0;
    int n_mismatch = 0;
    int check_count = 0;
    ////////////////////////////////////////////////////////////////////
    always #5 i_clk = ~i_clk;
    // Entries are counted so a spurious one shows up at the next check
    always @(posedge i_clk) begin
        if (take === 1'b1) begin
            n_take <= n_take + 1;
            cap <= {hx, lh, ll, vec, vaddr};
        end
    end
    nic_ctrl u_nic_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_instr_boundary(bnd), .i_op_enable_irq(ops[0]),
        .i_op_disable_irq(ops[1]), .i_op_halt(ops[2]), .i_op_wait_irq(ops[3]), .i_op_trap(ops[4]),
        .i_op_irq_return(ops[5]), .i_op_pop_cc(ops[6]), .i_pop_level(pop_lvl),
        .i_clock_timebase_req(req[0]), .i_periph_req({6'h00, req[1]}), .i_spi_slave(spi),
        .i_art_ext_clock(1'b0), .i_flash_variant(fa[1]), .i_active_halt(fa[0]), .i_top_level_pin(tlp),
        .i_port_a_pins(pa), .i_port_f_pins(pf), .i_port_b_pins(8'hff), .i_pin_en(pin_en),
        .o_take(take), .o_vector(vec), .o_vector_addr(vaddr), .o_level_bit_high(lh),
        .o_level_bit_low(ll), .o_jump_if_masked(jm), .o_jump_if_unmasked(jn), .o_halted(hlt),
        .o_halt_exit(hx));
    nic_src_model #(.VEC(4'h1)) u_nic_src_model_1 (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_raise(raise[0]), .i_take(take), .i_vector(vec), .o_req(req[0]));
    nic_src_model #(.VEC(4'h7)) u_nic_src_model_7 (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_raise(raise[1]), .i_take(take), .i_vector(vec), .o_req(req[1]));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        @(negedge i_clk);
        chk("rdata", {16'h0, exp}, {16'h0, rdata});
    endtask : rd_reg
    task automatic pulse(input int b, input logic [1:0] lvl);
        @(posedge i_clk);
        ops[b] <= 1'b1;
        pop_lvl <= lvl;
        @(posedge i_clk);
        ops[b] <= 1'b0;
    endtask : pulse
    task automatic rs(input int b);
        @(posedge i_clk);
        raise[b] <= 1'b1;
        @(posedge i_clk);
        raise[b] <= 1'b0;
    endtask : rs
    // Bounded wait for the next entry, then its vector, address and level
    task automatic wait_take(input logic [22:0] exp);
        for (int i = 0; i < 40 && n_take <= n_exp; i++) @(negedge i_clk);
        n_exp++;
        chk("count", n_exp[23:0], n_take[23:0]);
        chk("entry", {1'b0, exp}, {1'b0, cap});
    endtask : wait_take
    task automatic lvl(input logic [1:0] exp);
        @(negedge i_clk);
        chk("level", {22'h0, exp}, {22'h0, lh, ll});
        chk("jump", (exp == 2'h3) ? 24'h2 : 24'h1, {22'h0, jm, jn});
    endtask : lvl
    task automatic close_out;
        $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the 150 or so cycles the tests need
    initial begin
        #20000;
        n_mismatch++;
        close_out;
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        wait_take({3'b011, 4'hf, 16'hfffe});
        lvl(2'h3);
        for (int a = 0; a < 5; a++) rd_reg(8'h24 + a[7:0], (a < 4) ? 8'hff : 8'h00);
        rd_reg(8'h30, 8'h00);
        wr_reg(8'h24, 8'hcf);
        wr_reg(8'h24, 8'h64);
        wr_reg(8'h24, 8'h46);
        rd_reg(8'h24, 8'h44);
        wr_reg(8'h27, 8'h00);
        rd_reg(8'h27, 8'hf0);
        wr_reg(8'h28, 8'h10);
        rd_reg(8'h28, 8'h10);
        pulse(2, 2'h2);
        lvl(2'h2);
        chk("halted", 24'h1, {23'h0, hlt});
        rs(0);
        wait_take({3'b101, 4'h1, 16'hfff8});
        pulse(5, 2'h2);
        lvl(2'h2);
        wr_reg(8'h28, 8'hc0);
        rd_reg(8'h28, 8'h10);
        @(posedge i_clk);
        pa <= 4'he;
        wait_take({3'b000, 4'h2, 16'hfff6});
        pulse(5, 2'h2);
        pulse(1, 2'h2);
        lvl(2'h3);
        rs(1);
        repeat (10) @(negedge i_clk);
        pulse(4, 2'h2);
        wait_take({3'b011, 4'he, 16'hfffc});
        pulse(5, 2'h2);
        wait_take({3'b011, 4'h7, 16'hffec});
        pulse(6, 2'h1);
        lvl(2'h1);
        pulse(1, 2'h2);
        pulse(0, 2'h2);
        lvl(2'h2);
        pulse(3, 2'h2);
        lvl(2'h2);
        // Top-level request held off the boundary, then taken at level 3
        pulse(1, 2'h2);
        wr_reg(8'h28, 8'h11);
        @(posedge i_clk);
        bnd <= 1'b0;
        tlp <= 1'b0;
        repeat (10) @(negedge i_clk);
        chk("count", n_exp[23:0], n_take[23:0]);
        @(posedge i_clk);
        bnd <= 1'b1;
        tlp <= 1'b1;
        wait_take({3'b011, 4'h0, 16'hfffa});
        // Serial request leaves halt only in slave mode
        rs(1);
        pulse(2, 2'h2);
        repeat (10) @(negedge i_clk);
        chk("count", n_exp[23:0], n_take[23:0]);
        chk("halted", 24'h1, {23'h0, hlt});
        @(posedge i_clk);
        spi <= 1'b1;
        wait_take({3'b111, 4'h7, 16'hffec});
        // Active halt on the flash part wakes on the time base only
        pulse(5, 2'h2);
        @(posedge i_clk);
        fa <= 2'h3;
        pin_en <= 15'h0011;
        pulse(2, 2'h2);
        @(posedge i_clk);
        pf <= 3'h6;
        repeat (10) @(negedge i_clk);
        chk("count", n_exp[23:0], n_take[23:0]);
        rs(0);
        wait_take({3'b101, 4'h1, 16'hfff8});
        pulse(5, 2'h2);
        wait_take({3'b001, 4'h3, 16'hfff4});
        repeat (10) @(negedge i_clk);
        chk("count", n_exp[23:0], n_take[23:0]);
        close_out;
    end
endmodule : tb_top
